/* File: switch_qos_and_frame_policy.sv */
// Global frame policy: classification, queue weights, storm control, APB registers
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps
module switch_qos_and_frame_policy
  import qos_policy_pkg::*;
#(
  parameter int WINDOW_CYC = qos_policy_pkg::STORM_WINDOW_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic      [31:0] prdata,
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_data,
  input  wire logic        rx_sof,
  input  wire logic        rx_eof,
  input  wire logic        rx_crc_bad,
  input  wire logic        rx_port_prio,
  input  wire logic        rx_port_based,
  input  wire logic        rx_ip_over_tag_select,
  input  wire logic        all_ports_100,
  input  wire logic        buffer_pressure,
  output logic             cls_valid,
  output logic             cls_high_queue,
  output logic             cls_discard,
  output logic             cls_tagged,
  output logic             cls_ip,
  output logic      [3:0]  cls_vlan_group,
  input  wire logic        high_queue_pending,
  input  wire logic        low_queue_pending,
  input  wire logic        tx_slot,
  output logic             grant_valid,
  output logic             grant_high_queue,
  output logic             far_fault_detect_en,
  output logic             port_pair_aggregate_en,
  output logic      [6:0]  tx_gap_bits,
  output logic             aging_en,
  output logic             crc_check_en,
  output logic             storm_active,
  output logic      [6:0]  high_queue_drop_pct,
  output logic      [6:0]  low_queue_drop_pct
);
  import qos_policy_pkg::*;

  // Register file
  logic [15:0] global_policy_config_r;
  logic [15:0] tag_priority_queue_map_r;
  logic [15:0] ip_precedence_queue_map_r;
  logic [15:0] queue_and_storm_config_r;
  logic [31:0] prdata_r;
  logic [7:0]  reg_index;
  logic        addr_hit;
  logic        wr_en;
  logic [12:0] storm_count_r;
  logic        storm_r;

  // Registers sit one per aligned word; printed offsets are word indexes
  assign reg_index = paddr[9:2];
  assign addr_hit  = (paddr[31:10] == 22'h0) && (paddr[1:0] == 2'b00) &&
                     (reg_index == IDX_GLOBAL_CFG || reg_index == IDX_TAG_MAP ||
                      reg_index == IDX_IP_MAP || reg_index == IDX_QUEUE_CFG ||
                      reg_index == IDX_STORM_STAT);
  assign wr_en   = psel && penable && pwrite && addr_hit;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !addr_hit;
  assign prdata  = prdata_r;

  // Only documented writable bits take data; reserved bits keep their reset value
  function automatic logic [15:0] merge_w(input logic [15:0] d,
                                          input logic [15:0] mask,
                                          input logic [15:0] rst);
    merge_w = (d & mask) | (rst & ~mask);
  endfunction

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      global_policy_config_r    <= RST_GLOBAL_CFG;
      tag_priority_queue_map_r  <= RST_TAG_MAP;
      ip_precedence_queue_map_r <= RST_IP_MAP;
      queue_and_storm_config_r  <= RST_QUEUE_CFG;
    end else if (wr_en) begin
      unique case (reg_index)
        IDX_GLOBAL_CFG: begin
          global_policy_config_r <= merge_w(pwdata[15:0], WMASK_GLOBAL_CFG, RST_GLOBAL_CFG);
        end
        IDX_TAG_MAP: begin
          tag_priority_queue_map_r <= pwdata[15:0];
        end
        IDX_IP_MAP: begin
          ip_precedence_queue_map_r <= pwdata[15:0];
        end
        IDX_QUEUE_CFG: begin
          queue_and_storm_config_r <= merge_w(pwdata[15:0], WMASK_QUEUE_CFG, RST_QUEUE_CFG);
        end
        default: begin
        end
      endcase
    end
  end

  // Read data is captured in the setup phase so it leaves a flop in the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0;
    end else if (psel && !penable && !pwrite) begin
      if (reg_index == IDX_GLOBAL_CFG && addr_hit) begin
        prdata_r <= {16'h0, global_policy_config_r};
      end else if (reg_index == IDX_TAG_MAP && addr_hit) begin
        prdata_r <= {16'h0, tag_priority_queue_map_r};
      end else if (reg_index == IDX_IP_MAP && addr_hit) begin
        prdata_r <= {16'h0, ip_precedence_queue_map_r};
      end else if (reg_index == IDX_QUEUE_CFG && addr_hit) begin
        prdata_r <= {16'h0, queue_and_storm_config_r};
      end else if (reg_index == IDX_STORM_STAT && addr_hit) begin
        prdata_r <= {16'h0, storm_r, 2'b00, storm_count_r};
      end else begin
        prdata_r <= 32'h0;
      end
    end
  end

  // Field views
  logic       far_fault_ignore;
  logic       port_pair_aggregate_enable;
  logic       gap_leveling_enable;
  logic [1:0] queue_weight_select;
  logic [1:0] high_queue_drop_policy;
  logic [1:0] low_queue_drop_policy;
  logic       frame_check_off;
  logic       storm_filter_enable;
  logic [1:0] storm_threshold_select;

  assign far_fault_ignore           = global_policy_config_r[FAR_FAULT_BIT];
  assign port_pair_aggregate_enable = global_policy_config_r[TRUNK_BIT];
  assign gap_leveling_enable        = global_policy_config_r[GAP_LEVEL_BIT];
  assign queue_weight_select        = queue_and_storm_config_r[QWS_LSB +: 2];
  assign high_queue_drop_policy     = queue_and_storm_config_r[HDROP_LSB +: 2];
  assign low_queue_drop_policy      = queue_and_storm_config_r[LDROP_LSB +: 2];
  assign frame_check_off            = queue_and_storm_config_r[CRC_OFF_BIT];
  assign storm_filter_enable        = queue_and_storm_config_r[STORM_EN_BIT];
  assign storm_threshold_select     = queue_and_storm_config_r[STORM_SEL_LSB +: 2];

  function automatic logic [6:0] drop_pct(input logic [1:0] mode);
    unique case (mode)
      2'b10:   drop_pct = DROP_PCT_MID;
      2'b11:   drop_pct = DROP_PCT_HIGH;
      default: drop_pct = 7'd0;
    endcase
  endfunction

  // Per-mille of the 7490 reference; the 10M case is the same figures per mille of 749
  function automatic logic [12:0] storm_limit(input logic [1:0] sel,
                                              input logic       fast,
                                              input logic       rising);
    int pm;
    pm = 0;
    unique case (sel)
      2'b01:   pm = rising ? 100 : 50;
      2'b10:   pm = rising ? 200 : 100;
      2'b11:   pm = rising ? 400 : 200;
      default: pm = 0;
    endcase
    if (!fast) begin
      pm = pm / 10;
    end
    storm_limit = 13'((STORM_REF_FRAMES * pm) / 1000);
  endfunction

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      far_fault_detect_en    <= 1'b0;
      port_pair_aggregate_en <= 1'b0;
      tx_gap_bits            <= GAP_FULL_BITS;
      aging_en               <= 1'b1;
      crc_check_en           <= 1'b1;
      high_queue_drop_pct    <= 7'd0;
      low_queue_drop_pct     <= 7'd0;
    end else begin
      far_fault_detect_en    <= !far_fault_ignore;
      port_pair_aggregate_en <= port_pair_aggregate_enable;
      // Short gap only when leveling is on and the buffer needs draining
      tx_gap_bits <= (gap_leveling_enable && buffer_pressure) ?
                     GAP_SHORT_BITS : GAP_FULL_BITS;
      aging_en            <= !queue_and_storm_config_r[AGING_OFF_BIT];
      crc_check_en        <= !frame_check_off;
      high_queue_drop_pct <= drop_pct(high_queue_drop_policy);
      low_queue_drop_pct  <= drop_pct(low_queue_drop_policy);
    end
  end

  // Header capture
  frame_state_t fr_state_r;
  logic [4:0]   byte_idx_r;
  logic [15:0]  type_r;
  logic [15:0]  tci_r;
  logic [15:0]  inner_type_r;
  logic [7:0]   inner_tos_r;
  logic         bcast_r;
  logic         port_prio_r;
  logic         port_based_r;
  logic         ip_over_tag_r;
  logic [4:0]   byte_idx;

  assign byte_idx = rx_sof ? 5'd0 : byte_idx_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fr_state_r <= FR_IDLE;
      byte_idx_r <= 5'd0;
    end else if (rx_valid) begin
      if (rx_eof) begin
        fr_state_r <= FR_IDLE;
        byte_idx_r <= 5'd0;
      end else if (rx_sof || fr_state_r == FR_HEAD) begin
        fr_state_r <= (byte_idx == HDR_LAST_BYTE) ? FR_BODY : FR_HEAD;
        byte_idx_r <= byte_idx + 5'd1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      type_r        <= 16'h0;
      tci_r         <= 16'h0;
      inner_type_r  <= 16'h0;
      inner_tos_r   <= 8'h0;
      bcast_r       <= 1'b0;
      port_prio_r   <= 1'b0;
      port_based_r  <= 1'b0;
      ip_over_tag_r <= 1'b0;
    end else if (rx_valid && (rx_sof || fr_state_r == FR_HEAD)) begin
      if (rx_sof) begin
        type_r        <= 16'h0;
        inner_type_r  <= 16'h0;
        port_prio_r   <= rx_port_prio;
        port_based_r  <= rx_port_based;
        ip_over_tag_r <= rx_ip_over_tag_select;
      end
      // Destination all ones marks a broadcast frame
      if (byte_idx == 5'd0) begin
        bcast_r <= (rx_data == 8'hff);
      end else if (byte_idx < 5'd6) begin
        bcast_r <= bcast_r && (rx_data == 8'hff);
      end
      unique case (byte_idx)
        5'd12:   type_r[15:8]       <= rx_data;
        5'd13:   type_r[7:0]        <= rx_data;
        5'd14:   tci_r[15:8]        <= rx_data;
        5'd15:   tci_r[7:0]         <= rx_data;
        5'd16:   inner_type_r[15:8] <= rx_data;
        5'd17:   inner_type_r[7:0]  <= rx_data;
        5'd19:   inner_tos_r        <= rx_data;
        default: begin
        end
      endcase
    end
  end

  // Classification at the end of frame uses the maps as they stand then, so a
  // write lands only on later frames and nothing already queued changes.
  logic       is_tagged;
  logic       is_ip;
  logic       inner_ip;
  logic [2:0] user_prio;
  logic [2:0] ip_prec;
  logic       queue_sel;
  logic       is_bcast;

  assign is_tagged = (type_r == TYPE_TAGGED);
  assign is_ip     = (type_r == TYPE_IP);
  assign inner_ip  = is_tagged && (inner_type_r == TYPE_IP);
  assign user_prio = tci_r[15:13];
  assign ip_prec   = !inner_ip ? tci_r[7:5] : (byte_idx == HDR_LAST_BYTE) ? rx_data[7:5] :
                     inner_tos_r[7:5];
  assign is_bcast  = bcast_r && (byte_idx_r > 5'd5 || fr_state_r == FR_BODY);

  // Only field value 01 places a frame in the high queue
  function automatic logic map_high(input logic [15:0] map, input logic [2:0] v);
    map_high = (map[{v, 1'b0} +: 2] == 2'b01);
  endfunction

  always_comb begin
    if (port_based_r) begin
      queue_sel = port_prio_r;
    end else if (inner_ip) begin
      queue_sel = ip_over_tag_r ? map_high(ip_precedence_queue_map_r, ip_prec) :
                  map_high(tag_priority_queue_map_r, user_prio);
    end else if (is_tagged) begin
      queue_sel = map_high(tag_priority_queue_map_r, user_prio);
    end else if (is_ip) begin
      queue_sel = map_high(ip_precedence_queue_map_r, ip_prec);
    end else begin
      queue_sel = port_prio_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cls_valid      <= 1'b0;
      cls_high_queue <= 1'b0;
      cls_discard    <= 1'b0;
      cls_tagged     <= 1'b0;
      cls_ip         <= 1'b0;
      cls_vlan_group <= 4'h0;
    end else begin
      cls_valid <= rx_valid && rx_eof && fr_state_r != FR_IDLE;
      if (rx_valid && rx_eof && fr_state_r != FR_IDLE) begin
        cls_high_queue <= queue_sel;
        cls_discard    <= (rx_crc_bad && !frame_check_off) ||
                          (is_bcast && storm_r);
        cls_tagged     <= is_tagged;
        cls_ip         <= is_ip || inner_ip;
        cls_vlan_group <= tci_r[3:0];
      end
    end
  end

  // Broadcast storm window
  logic [31:0] win_cnt_r;
  logic        win_end;
  logic        bcast_seen;
  logic [12:0] count_nxt;
  logic        storm_armed;

  assign win_end     = (win_cnt_r == 32'(WINDOW_CYC - 1));
  assign bcast_seen  = rx_valid && rx_eof && fr_state_r != FR_IDLE && is_bcast;
  assign count_nxt   = (bcast_seen && storm_count_r != 13'h1fff) ?
                       storm_count_r + 13'd1 : storm_count_r;
  assign storm_armed = storm_filter_enable && storm_threshold_select != 2'b00;
  assign storm_active = storm_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      win_cnt_r     <= 32'h0;
      storm_count_r <= 13'h0;
      storm_r       <= 1'b0;
    end else begin
      win_cnt_r     <= win_end ? 32'h0 : win_cnt_r + 32'h1;
      storm_count_r <= win_end ? 13'h0 : count_nxt;
      if (!storm_armed) begin
        storm_r <= 1'b0;
      end else if (count_nxt > storm_limit(storm_threshold_select, all_ports_100, 1'b1)) begin
        storm_r <= 1'b1;
      end else if (win_end &&
                   count_nxt <= storm_limit(storm_threshold_select, all_ports_100, 1'b0)) begin
        storm_r <= 1'b0;
      end
    end
  end

  // Weighted round robin between the two queues
  logic [2:0] high_run_r;
  logic [2:0] weight;

  assign weight = {1'b0, queue_weight_select} + 3'd1;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      grant_valid      <= 1'b0;
      grant_high_queue <= 1'b0;
      high_run_r       <= 3'd0;
    end else begin
      grant_valid <= tx_slot && (high_queue_pending || low_queue_pending);
      if (tx_slot) begin
        if (high_queue_pending && (!low_queue_pending || high_run_r < weight)) begin
          grant_high_queue <= 1'b1;
          high_run_r       <= low_queue_pending ? high_run_r + 3'd1 : 3'd0;
        end else if (low_queue_pending) begin
          grant_high_queue <= 1'b0;
          high_run_r       <= 3'd0;
        end
      end
    end
  end
endmodule

/* File: qos_policy_pkg.sv */
// Constants for the switch frame policy and queue scheduling block
package qos_policy_pkg;
  localparam logic [7:0]  IDX_GLOBAL_CFG   = 8'h0b;
  localparam logic [7:0]  IDX_TAG_MAP      = 8'h0e;
  localparam logic [7:0]  IDX_IP_MAP       = 8'h0f;
  localparam logic [7:0]  IDX_QUEUE_CFG    = 8'h10;
  localparam logic [7:0]  IDX_STORM_STAT   = 8'h20;
  localparam logic [15:0] RST_GLOBAL_CFG   = 16'h8000;
  localparam logic [15:0] RST_TAG_MAP      = 16'h5500;
  localparam logic [15:0] RST_IP_MAP       = 16'h5500;
  localparam logic [15:0] RST_QUEUE_CFG    = 16'h0040;
  localparam logic [15:0] WMASK_GLOBAL_CFG = 16'h80c0;
  localparam logic [15:0] WMASK_QUEUE_CFG  = 16'h3f97;
  localparam int          FAR_FAULT_BIT    = 15;
  localparam int          TRUNK_BIT        = 7;
  localparam int          GAP_LEVEL_BIT    = 6;
  localparam int          QWS_LSB          = 12;
  localparam int          HDROP_LSB        = 10;
  localparam int          LDROP_LSB        = 8;
  localparam int          AGING_OFF_BIT    = 7;
  localparam int          CRC_OFF_BIT      = 4;
  localparam int          STORM_EN_BIT     = 2;
  localparam int          STORM_SEL_LSB    = 0;
  localparam logic [15:0] TYPE_TAGGED      = 16'h8100;
  localparam logic [15:0] TYPE_IP          = 16'h0800;
  localparam logic [6:0]  GAP_FULL_BITS    = 7'd96;
  localparam logic [6:0]  GAP_SHORT_BITS   = 7'd92;
  localparam logic [4:0]  HDR_LAST_BYTE    = 5'd19;
  localparam int          CLK_HZ           = 10_000_000;
  localparam int          STORM_WINDOW_MS  = 50;
  localparam int          STORM_WINDOW_CYC = CLK_HZ / 1000 * STORM_WINDOW_MS;
  localparam int          STORM_REF_FRAMES = 7490;
  localparam logic [6:0]  DROP_PCT_MID     = 7'd25;
  localparam logic [6:0]  DROP_PCT_HIGH    = 7'd50;
  typedef enum logic [1:0] {
    FR_IDLE = 2'b00,
    FR_HEAD = 2'b01,
    FR_BODY = 2'b11
  } frame_state_t;
endpackage

/* File: qos_policy_checker_assertions.sv */
// Port checker for the frame policy block
`timescale 1ns/1ps
module qos_policy_checker
  import qos_policy_pkg::*;
#(
  parameter int WINDOW_CYC = 200
) (
  input logic        pclk,
  input logic        presetn,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [31:0] paddr,
  input logic [31:0] pwdata,
  input logic        pslverr,
  input logic        rx_valid,
  input logic        rx_eof,
  input logic        buffer_pressure,
  input logic        cls_valid,
  input logic        high_queue_pending,
  input logic        low_queue_pending,
  input logic        tx_slot,
  input logic        grant_valid,
  input logic        grant_high_queue,
  input logic        far_fault_detect_en,
  input logic        port_pair_aggregate_en,
  input logic [6:0]  tx_gap_bits,
  input logic        aging_en,
  input logic [6:0]  high_queue_drop_pct
);
  localparam logic [31:0] GA = {22'h0, IDX_GLOBAL_CFG, 2'b00};
  localparam logic [31:0] QA = {22'h0, IDX_QUEUE_CFG, 2'b00};
  logic [3:0] run_r;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // High grants in a row while low waits; the widest ratio allows four
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) run_r <= 4'h0;
    else if (!low_queue_pending) run_r <= 4'h0;
    else if (grant_valid) run_r <= grant_high_queue ? run_r + 4'h1 : 4'h0;
  end
  far_fault_a: assert property (psel && penable && pwrite && paddr == GA |=> ##1
    far_fault_detect_en == !$past(pwdata[FAR_FAULT_BIT], 2)) else $error("far fault enable");
  trunk_pair_a: assert property (psel && penable && pwrite && paddr == GA |=> ##1
    port_pair_aggregate_en == $past(pwdata[TRUNK_BIT], 2)) else $error("trunk enable");
  short_gap_a: assert property (tx_gap_bits != GAP_FULL_BITS |->
    tx_gap_bits == GAP_SHORT_BITS && ($past(buffer_pressure) || $past(buffer_pressure, 2)))
    else $error("gap length");
  aging_ctl_a: assert property (psel && penable && pwrite && paddr == QA |=> ##1
    aging_en == !$past(pwdata[AGING_OFF_BIT], 2)) else $error("aging enable");
  high_drop_a: assert property (psel && penable && pwrite && paddr == QA |=> ##1
    high_queue_drop_pct == ($past(pwdata[11], 2) ? ($past(pwdata[10], 2) ? DROP_PCT_HIGH
    : DROP_PCT_MID) : 7'h00)) else $error("high queue drop");
  cls_pulse_a: assert property (rx_valid && rx_eof |=> cls_valid ##1 !cls_valid)
    else $error("classification pulse");
  grant_given_a: assert property (tx_slot && (high_queue_pending || low_queue_pending)
    |=> grant_valid) else $error("grant missing");
  grant_cause_a: assert property (grant_valid |-> $past(tx_slot) &&
    ($past(high_queue_pending) || $past(low_queue_pending))) else $error("grant uncaused");
  lone_queue_a: assert property (tx_slot && (high_queue_pending ^ low_queue_pending) |=>
    grant_high_queue == $past(high_queue_pending)) else $error("lone queue");
  weight_run_a: assert property (run_r <= 4'h4) else $error("high run too long");
  bad_addr_a: assert property (psel && penable && paddr[1:0] != 2'b00 |-> pslverr)
    else $error("misaligned accepted");
endmodule
bind switch_qos_and_frame_policy qos_policy_checker #(.WINDOW_CYC(WINDOW_CYC)) chk_i (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pslverr, .rx_valid, .rx_eof,
  .buffer_pressure, .cls_valid, .high_queue_pending, .low_queue_pending, .tx_slot,
  .grant_valid, .grant_high_queue, .far_fault_detect_en, .port_pair_aggregate_en,
  .tx_gap_bits, .aging_en, .high_queue_drop_pct);

/* File: link_partner.sv */
// Behavioural link partner streaming frame bytes
`timescale 1ns/1ps
module link_partner (
  input  logic       pclk,
  output logic       rx_valid,
  output logic [7:0] rx_data,
  output logic       rx_sof,
  output logic       rx_eof,
  output logic       rx_crc_bad,
  output logic       rx_port_prio,
  output logic       rx_port_based,
  output logic       rx_ip_over_tag_select
);
  initial {rx_valid, rx_sof, rx_eof, rx_crc_bad, rx_port_prio, rx_port_based,
           rx_ip_over_tag_select, rx_data} = 15'h00a5;
  // Idle data flips so a stale byte never passes for a live one
  task automatic send(input logic [15:0] ty, tci, inner, input logic [7:0] ip_over_tag_select,
                      input logic bc, crc, pp, pb, sel, input int len);
    logic [7:0] b;
    for (int i = 0; i < len; i++) begin
      b = i < 6 ? (bc ? 8'hff : 8'h0a) : i < 12 ? 8'h0c : i == 12 ? ty[15:8] :
          i == 13 ? ty[7:0] : i == 14 ? tci[15:8] : i == 15 ? tci[7:0] :
          i == 16 ? inner[15:8] : i == 17 ? inner[7:0] : i == 19 ? ip_over_tag_select : i[7:0];
      @(posedge pclk);
      rx_valid <= 1'b1;
      rx_data <= b;
      rx_sof <= i == 0;
      rx_eof <= i == len - 1;
      rx_crc_bad <= crc;
      rx_port_prio <= pp;
      rx_port_based <= pb;
      rx_ip_over_tag_select <= sel;
    end
    @(posedge pclk);
    rx_valid <= 1'b0;
    rx_eof <= 1'b0;
    rx_data <= ~rx_data;
  endtask
endmodule

/* File: switch_qos_and_frame_policy_tb.sv */
// Self-checking bench for the frame policy block
`timescale 1ns/1ps
module switch_qos_and_frame_policy_tb;
  import qos_policy_pkg::*;
  localparam logic [31:0] A_G = {22'h0, IDX_GLOBAL_CFG, 2'b00};
  localparam logic [31:0] A_T = {22'h0, IDX_TAG_MAP, 2'b00};
  localparam logic [31:0] A_I = {22'h0, IDX_IP_MAP, 2'b00};
  localparam logic [31:0] A_Q = {22'h0, IDX_QUEUE_CFG, 2'b00};
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, v, r, q;
  logic        pready, pslverr, e, seen_st, seen_dc;
  logic        rx_valid, rx_sof, rx_eof, rx_crc_bad, rx_port_prio, rx_port_based;
  logic        rx_ip_over_tag_select, cls_valid, cls_high_queue, cls_discard, cls_tagged;
  logic [7:0]  rx_data;
  logic        all_ports_100 = 1'b0, buffer_pressure = 1'b0, tx_slot = 1'b0;
  logic        high_queue_pending = 1'b0, low_queue_pending = 1'b0;
  logic        cls_ip, grant_valid, grant_high_queue, far_fault_detect_en;
  logic        port_pair_aggregate_en, aging_en, crc_check_en, storm_active;
  logic [3:0]  cls_vlan_group;
  logic [6:0]  tx_gap_bits, high_queue_drop_pct, low_queue_drop_pct;
  logic [15:0] tm, im, ty;
  logic [1:0]  kd;
  int          error_cnt = 0, checks_done = 0, seed = 32'h55de5db6;
  always #50 pclk = ~pclk;
  switch_qos_and_frame_policy #(.WINDOW_CYC(2000)) dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .prdata,
    .rx_valid, .rx_data, .rx_sof, .rx_eof, .rx_crc_bad, .rx_port_prio, .rx_port_based,
    .rx_ip_over_tag_select, .all_ports_100, .buffer_pressure, .cls_valid, .cls_high_queue,
    .cls_discard, .cls_tagged, .cls_ip, .cls_vlan_group, .high_queue_pending,
    .low_queue_pending, .tx_slot, .grant_valid, .grant_high_queue, .far_fault_detect_en,
    .port_pair_aggregate_en, .tx_gap_bits, .aging_en, .crc_check_en, .storm_active,
    .high_queue_drop_pct, .low_queue_drop_pct);
  link_partner lp (.pclk, .rx_valid, .rx_data, .rx_sof, .rx_eof, .rx_crc_bad, .rx_port_prio,
    .rx_port_based, .rx_ip_over_tag_select);
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [31:0] a, d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rc(input logic [31:0] a, exp);
    apb(1'b0, a, 32'h0);
    chk("read data", r, exp);
  endtask
  task automatic slot(input logic h, l);
    @(posedge pclk);
    high_queue_pending <= h;
    low_queue_pending <= l;
    tx_slot <= 1'b1;
    @(posedge pclk);
    tx_slot <= 1'b0;
    @(negedge pclk);
  endtask
  function automatic logic [6:0] pct(input logic [1:0] c);
    return c[1] ? (c[0] ? DROP_PCT_HIGH : DROP_PCT_MID) : 7'h00;
  endfunction
  // Field value 01 alone means the high queue
  function automatic logic exp_high(input logic [1:0] k, input logic [15:0] t, i, tci,
                                    input logic [7:0] ip_over_tag_select, input logic pp, pb, sel);
    if (pb || k == 2'h0) return pp;
    if (k == 2'h2) return i[2*tci[7:5] +: 2] == 2'h1;
    if (k == 2'h3 && sel) return i[2*ip_over_tag_select[7:5] +: 2] == 2'h1;
    return t[2*tci[15:13] +: 2] == 2'h1;
  endfunction
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #(100 * 40000);
    error_cnt++;
    print_verdict();
  end
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rc(A_G, 32'h8000);
    rc(A_T, 32'h5500);
    rc(A_I, 32'h5500);
    rc(A_Q, 32'h0040);
    apb(1'b1, A_G + 32'h2, 32'h0);
    chk("misaligned err", e, 1'b1);
    apb(1'b0, 32'h44, 32'h0);
    chk("unmapped err", e, 1'b1);
    rc(A_G, 32'h8000);
    chk("aging", aging_en, 1'b1);
    chk("crc check", crc_check_en, 1'b1);
    chk("storm", storm_active, 1'b0);
    $display("reset test done");
    for (int k = 0; k < 6; k++) begin
      v = k == 0 ? 32'hffff : k == 1 ? 32'h0 : $random(seed);
      buffer_pressure <= v[0];
      apb(1'b1, A_G, v);
      rc(A_G, v[15:0] & WMASK_GLOBAL_CFG);
      @(negedge pclk);
      chk("far fault en", far_fault_detect_en, !v[15]);
      chk("trunk", port_pair_aggregate_en, v[7]);
      chk("gap", tx_gap_bits, v[6] && v[0] ? GAP_SHORT_BITS : GAP_FULL_BITS);
    end
    $display("global test done");
    for (int k = 0; k < 8; k++) begin
      v = $random(seed);
      v[11:8] = {k[1:0], ~k[1:0]};
      apb(1'b1, A_Q, v);
      rc(A_Q, (v[15:0] & WMASK_QUEUE_CFG) | 32'h40);
      @(negedge pclk);
      chk("aging", aging_en, !v[7]);
      chk("crc check", crc_check_en, !v[4]);
      chk("high drop", high_queue_drop_pct, pct(v[11:10]));
      chk("low drop", low_queue_drop_pct, pct(v[9:8]));
    end
    apb(1'b1, A_Q, 32'h0);
    $display("queue config test done");
    for (int k = 0; k < 40; k++) begin
      tm = $random(seed);
      im = $random(seed);
      r = $random(seed);
      q = $random(seed);
      kd = k < 4 ? k[1:0] : q[1:0];
      apb(1'b1, A_T, tm);
      rc(A_T, tm);
      apb(1'b1, A_I, im);
      rc(A_I, im);
      ty = kd[0] ? TYPE_TAGGED : kd[1] ? TYPE_IP : 16'h0600;
      lp.send(ty, q[31:16], kd == 2'h3 ? TYPE_IP : 16'h0600, r[7:0], 1'b0, r[11], r[8],
              r[9] && k >= 4, r[10], 20 + r[14:12]);
      @(negedge pclk);
      chk("cls valid", cls_valid, 1'b1);
      chk("queue", cls_high_queue, exp_high(kd, tm, im, q[31:16], r[7:0], r[8],
          r[9] && k >= 4, r[10]));
      chk("tagged", cls_tagged, kd[0]);
      chk("ip", cls_ip, kd[1]);
      if (kd[0]) chk("vlan group", cls_vlan_group, q[19:16]);
      chk("discard", cls_discard, r[11]);
    end
    $display("classify test done");
    seen_st = 1'b0;
    seen_dc = 1'b0;
    apb(1'b1, A_Q, 32'h5);
    for (int k = 0; k < 160; k++) begin
      lp.send(16'h0600, 16'h0, 16'h0, 8'h0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 7);
      @(negedge pclk);
      seen_st = seen_st | storm_active;
      seen_dc = seen_dc | cls_discard;
    end
    chk("storm seen", seen_st, 1'b1);
    chk("storm discard", seen_dc, 1'b1);
    apb(1'b1, A_Q, 32'h4);
    lp.send(16'h0600, 16'h0, 16'h0, 8'h0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 7);
    @(negedge pclk);
    chk("storm off", storm_active, 1'b0);
    chk("no discard", cls_discard, 1'b0);
    apb(1'b1, A_Q, 32'h5);
    for (int k = 0; k < 160; k++)
      lp.send(16'h0600, 16'h0, 16'h0, 8'h0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 7);
    @(negedge pclk);
    chk("storm held", storm_active, 1'b1);
    repeat (4100) @(negedge pclk);
    chk("storm fall", storm_active, 1'b0);
    $display("storm test done");
    for (int w = 0; w < 4; w++) begin
      apb(1'b1, A_Q, {18'h0, w[1:0], 12'h0});
      slot(1'b1, 1'b0);
      chk("lone high", grant_high_queue, 1'b1);
      for (int i = 0; i < 2 * (w + 2); i++) begin
        slot(1'b1, 1'b1);
        chk("grant", grant_valid, 1'b1);
        chk("weight", grant_high_queue, (i % (w + 2)) != w + 1);
      end
    end
    slot(1'b0, 1'b1);
    chk("lone low", grant_high_queue, 1'b0);
    slot(1'b0, 1'b0);
    chk("no grant", grant_valid, 1'b0);
    $display("scheduler test done");
    print_verdict();
  end
endmodule
